// ==== design/csr_space.sv ====
// CPU special register space: decoder, core registers and placed peripheral storage
`timescale 1ns/1ps
module csr_space
   import csr_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_resetn,
   // Byte and bit access from the instruction stream
   input wire csr_byte_req_t i_byte_req,
   input wire csr_bit_req_t i_bit_req,
   output logic [7:0] o_rdata,
   output logic o_bit_rdata,
   output logic o_rvalid,
   // Core datapath operations
   input wire csr_core_op_t i_core_op,
   // Wake events from the interrupt logic
   input wire logic i_ext_wake,
   input wire logic i_per_wake,
   // Mode select pin
   input wire logic i_mode_select_pin,
   // State shown to the core and the system
   output logic [7:0] o_acc,
   output logic [7:0] o_stack_ptr,
   output logic [15:0] o_data_ptr,
   output logic [1:0] o_bank_select_field,
   output logic [7:0] o_page_address_port,
   output logic o_nvm_low_power_enable,
   output logic o_power_down,
   output logic o_cpu_clk_stop,
   // Writes forwarded to peripheral owners
   output csr_per_wr_t o_per_wr
);

   // Location decode for the peripherals placed in the map
   function automatic logic is_periph(input logic [7:0] a);
      case (a)
         8'h98, 8'h99, 8'h9A, 8'h92: is_periph = 1'b1;
         8'hA8, 8'hB8, 8'hE8, 8'hE9, 8'hF8, 8'hF9, 8'h91, 8'hD8: is_periph = 1'b1;
         8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hA9: is_periph = 1'b1;
         8'hAA, 8'hAB, 8'hAC, 8'hAD: is_periph = 1'b1;
         8'hD2: is_periph = 1'b1;
         8'h80, 8'h90, 8'hA0, 8'hB0, 8'hB1, 8'hB2, 8'hB4: is_periph = 1'b1;
         8'hB9, 8'hBA, 8'hBC, 8'hC1, 8'hC2, 8'hC4, 8'hD9, 8'hDA, 8'hDC: is_periph = 1'b1;
         8'hE1, 8'hE2, 8'hE4, 8'hEA, 8'hEB, 8'hEC, 8'hED: is_periph = 1'b1;
         8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hFA, 8'hFB, 8'hFC, 8'hFD: is_periph = 1'b1;
         default: is_periph = 1'b0;
      endcase
   endfunction

   // Location decode for registers held in the core
   function automatic logic is_core(input logic [7:0] a);
      is_core = (a == CSR_A_STACK) || (a == CSR_A_PTR_LO) || (a == CSR_A_PTR_HI) ||
                (a == CSR_A_POWER) || (a == CSR_A_PTR_SEL) || (a == CSR_A_WCTRL) ||
                (a == CSR_A_STATUS) || (a == CSR_A_ACC) || (a == CSR_A_AUX);
   endfunction

   // Reset value of a placed peripheral slot
   function automatic logic [7:0] per_reset(input logic [7:0] a);
      if (a == CSR_A_GATE0)
         per_reset = CSR_RST_GATE0;
      else if (a == CSR_A_GATE2)
         per_reset = CSR_RST_GATE2;
      else if (a == CSR_A_GATE3)
         per_reset = CSR_RST_GATE3;
      else
         per_reset = CSR_RST_ZERO;
   endfunction

   // Core registers
   logic [7:0] acc_q; // Accumulator
   logic [7:0] aux_q; // Multiply/divide auxiliary
   logic [7:0] status_q; // Status word, parity slot unused
   logic [7:0] sp_q; // Stack pointer
   logic [15:0] ptr_q [0:1]; // Two physical data pointers
   logic choice_q; // Pointer choice bit
   logic lowpwr_q; // Low-power fetch enable
   logic sleep_q; // Sleep request bit
   logic idle_q; // CPU clock stop bit
   logic [7:0] per_mem_q [0:CSR_PER_DEPTH-1]; // Placed peripheral bytes
   logic mode_meta_q; // Pin synchroniser, first stage
   logic boot_q; // Pin synchroniser, second stage

   // Merged write path
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] bit_byte_addr;
   logic [2:0] bit_idx;
   logic [7:0] bit_old;
   logic [7:0] rd_view;
   logic parity;
   logic [15:0] product;
   logic [15:0] ptr_d [0:1];
   logic choice_d;

   // Parity of the accumulator, read through the status word
   assign parity = ^acc_q;
   assign product = acc_q * aux_q;

   // Bit address splits into byte address and bit index
   assign bit_byte_addr = {i_bit_req.addr[7:CSR_BIT_IDX_W], 3'h0};
   assign bit_idx = i_bit_req.addr[CSR_BIT_IDX_W-1:0];

   // Read view of one byte location, zero where nothing exists
   function automatic logic [7:0] view(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == CSR_A_STACK)
         v = sp_q;
      else if (a == CSR_A_PTR_LO)
         v = ptr_q[choice_q][7:0];
      else if (a == CSR_A_PTR_HI)
         v = ptr_q[choice_q][15:8];
      else if (a == CSR_A_POWER)
      begin
         v[CSR_PC_SLEEP] = sleep_q;
         v[CSR_PC_IDLE] = idle_q;
      end
      else if (a == CSR_A_PTR_SEL)
         v[CSR_PS_CHOICE] = choice_q;
      else if (a == CSR_A_WCTRL)
      begin
         v[CSR_WC_BOOT] = boot_q;
         v[CSR_WC_LOWPWR] = lowpwr_q;
         v[CSR_WC_FIXED1] = 1'b1;
      end
      else if (a == CSR_A_STATUS)
      begin
         v = status_q;
         v[CSR_ST_PAR] = parity;
      end
      else if (a == CSR_A_ACC)
         v = acc_q;
      else if (a == CSR_A_AUX)
         v = aux_q;
      else if (is_periph(a))
         v = per_mem_q[a[6:0]];
      view = v;
   endfunction

   // Byte write wins; a bit write is a read-modify-write of its byte
   always_comb
   begin
      bit_old = view(bit_byte_addr);
      rd_view = view(i_byte_req.addr);
      wr_en = 1'b0;
      wr_addr = i_byte_req.addr;
      wr_data = i_byte_req.wdata;
      if (i_byte_req.wr && i_byte_req.addr[7])
         wr_en = 1'b1;
      else if (i_bit_req.wr && i_bit_req.addr[7])
      begin
         wr_en = 1'b1;
         wr_addr = bit_byte_addr;
         wr_data = bit_old;
         wr_data[bit_idx] = i_bit_req.wdata;
      end
   end

   // Read answer one cycle after the request
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_rdata <= 8'h00;
         o_bit_rdata <= 1'b0;
         o_rvalid <= 1'b0;
      end
      else
      begin
         o_rvalid <= i_byte_req.rd || i_bit_req.rd;
         o_rdata <= rd_view;
         o_bit_rdata <= bit_old[bit_idx];
      end
   end

   // Mode select pin synchroniser; boot flag follows the pin level
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         mode_meta_q <= 1'b0;
         boot_q <= 1'b0;
      end
      else
      begin
         mode_meta_q <= i_mode_select_pin;
         boot_q <= mode_meta_q;
      end
   end

   // Accumulator and auxiliary register; no clear other than reset
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         acc_q <= CSR_RST_ZERO;
         aux_q <= CSR_RST_ZERO;
      end
      else if (wr_en && (wr_addr == CSR_A_ACC))
         acc_q <= wr_data;
      else if (wr_en && (wr_addr == CSR_A_AUX))
         aux_q <= wr_data;
      else if (i_core_op.mul)
      begin
         acc_q <= product[7:0];
         aux_q <= product[15:8];
      end
      else if (i_core_op.div && (acc_q != 8'h00))
      begin
         acc_q <= aux_q / acc_q;
         aux_q <= aux_q % acc_q;
      end
      else if (i_core_op.acc_wr)
         acc_q <= i_core_op.acc_data;
   end

   // Status word: software write, then arithmetic flag updates
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         status_q <= CSR_RST_ZERO;
      else if (wr_en && (wr_addr == CSR_A_STATUS))
         status_q <= wr_data;
      else if (i_core_op.mul || i_core_op.div)
      begin
         status_q[CSR_ST_CY] <= 1'b0;
         // Overflow on a wide product or a zero divisor
         status_q[CSR_ST_OV] <= i_core_op.mul ? (product[15:8] != 8'h00) : (acc_q == 8'h00);
      end
      else if (i_core_op.flag_wr)
      begin
         status_q[CSR_ST_CY] <= i_core_op.cy;
         status_q[CSR_ST_AC] <= i_core_op.ac;
         status_q[CSR_ST_OV] <= i_core_op.ov;
      end
   end

   // Stack pointer: push increments before the store, pop after the read
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         sp_q <= CSR_RST_STACK;
      else if (wr_en && (wr_addr == CSR_A_STACK))
         sp_q <= wr_data;
      else if (i_core_op.push)
         sp_q <= sp_q + 8'h01;
      else if (i_core_op.pop)
         sp_q <= sp_q - 8'h01;
   end

   // Next values of both data pointers and the choice bit
   always_comb
   begin
      ptr_d[0] = ptr_q[0];
      ptr_d[1] = ptr_q[1];
      choice_d = choice_q;
      if (wr_en && (wr_addr == CSR_A_PTR_SEL))
         choice_d = wr_data[CSR_PS_CHOICE];
      else if (wr_en && (wr_addr == CSR_A_PTR_LO))
         ptr_d[choice_q][7:0] = wr_data;
      else if (wr_en && (wr_addr == CSR_A_PTR_HI))
         ptr_d[choice_q][15:8] = wr_data;
      else if (i_core_op.ptr_load)
         ptr_d[choice_q] = i_core_op.ptr_data;
      else if (i_core_op.ptr_inc)
         ptr_d[choice_q] = ptr_q[choice_q] + 16'h0001;
   end

   // Data pointer storage and the visible pointer copy
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         ptr_q[0] <= {CSR_RST_ZERO, CSR_RST_ZERO};
         ptr_q[1] <= {CSR_RST_ZERO, CSR_RST_ZERO};
         choice_q <= 1'b0;
         o_data_ptr <= {CSR_RST_ZERO, CSR_RST_ZERO};
      end
      else
      begin
         ptr_q[0] <= ptr_d[0];
         ptr_q[1] <= ptr_d[1];
         choice_q <= choice_d;
         o_data_ptr <= ptr_d[choice_d];
      end
   end

   // Power control; a software set in the wake cycle wins
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         sleep_q <= 1'b0;
         idle_q <= 1'b0;
      end
      else
      begin
         if (wr_en && (wr_addr == CSR_A_POWER) && wr_data[CSR_PC_SLEEP])
            sleep_q <= 1'b1;
         else if (i_ext_wake || (wr_en && (wr_addr == CSR_A_POWER)))
            sleep_q <= 1'b0;
         if (wr_en && (wr_addr == CSR_A_POWER) && wr_data[CSR_PC_IDLE])
            idle_q <= 1'b1;
         else if (i_per_wake || (wr_en && (wr_addr == CSR_A_POWER)))
            idle_q <= 1'b0;
      end
   end

   // Write control: only the low-power bit is writable
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         lowpwr_q <= 1'b0;
      else if (wr_en && (wr_addr == CSR_A_WCTRL))
         lowpwr_q <= wr_data[CSR_WC_LOWPWR];
   end

   // Placed peripheral storage; empty locations take no write
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         for (int i = 0; i < CSR_PER_DEPTH; i++)
            per_mem_q[i] <= per_reset(8'(i + CSR_PER_DEPTH));
      end
      else if (wr_en && is_periph(wr_addr))
         per_mem_q[wr_addr[6:0]] <= wr_data;
   end

   // Forward peripheral writes to their owners
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_per_wr <= '0;
      else
      begin
         o_per_wr.valid <= wr_en && is_periph(wr_addr);
         o_per_wr.addr <= wr_addr;
         o_per_wr.data <= wr_data;
      end
   end

   // Registered state outputs
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_acc <= CSR_RST_ZERO;
         o_stack_ptr <= CSR_RST_STACK;
         o_bank_select_field <= 2'h0;
         o_page_address_port <= CSR_RST_ZERO;
         o_nvm_low_power_enable <= 1'b0;
         o_power_down <= 1'b0;
         o_cpu_clk_stop <= 1'b0;
      end
      else
      begin
         o_acc <= acc_q;
         o_stack_ptr <= sp_q;
         o_bank_select_field <= status_q[CSR_ST_BANK_HI:CSR_ST_BANK_LO];
         o_page_address_port <= per_mem_q[CSR_A_PAGE[6:0]];
         o_nvm_low_power_enable <= lowpwr_q;
         o_power_down <= sleep_q;
         o_cpu_clk_stop <= idle_q;
      end
   end

   // Checks
   property p_empty_read;
      @(posedge i_clk) disable iff (!i_resetn)
      (i_byte_req.rd && !is_core(i_byte_req.addr) && !is_periph(i_byte_req.addr))
         |=> (o_rvalid && (o_rdata == 8'h00));
   endproperty
   a_empty_read: assert property (p_empty_read) else $error("empty read not zero");

   property p_empty_write;
      @(posedge i_clk) disable iff (!i_resetn)
      (i_byte_req.wr && i_byte_req.addr[7] && !is_core(i_byte_req.addr)
         && !is_periph(i_byte_req.addr)) |=> !o_per_wr.valid;
   endproperty
   a_empty_write: assert property (p_empty_write) else $error("empty write stored");

   property p_bit_write;
      @(posedge i_clk) disable iff (!i_resetn)
      (i_bit_req.wr && !i_byte_req.wr && (bit_byte_addr == CSR_A_AUX))
         |=> (aux_q[$past(bit_idx)] == $past(i_bit_req.wdata));
   endproperty
   a_bit_write: assert property (p_bit_write) else $error("bit write lost");

   property p_parity;
      @(posedge i_clk) disable iff (!i_resetn)
      (i_byte_req.rd && (i_byte_req.addr == CSR_A_STATUS))
         |=> (o_rdata[CSR_ST_PAR] == ^$past(acc_q));
   endproperty
   a_parity: assert property (p_parity) else $error("parity wrong");

   property p_push;
      @(posedge i_clk) disable iff (!i_resetn)
      (i_core_op.push && !wr_en) |=> ##1 (o_stack_ptr == $past(sp_q, 2) + 8'h01);
   endproperty
   a_push: assert property (p_push) else $error("push did not increment");

   property p_mul;
      @(posedge i_clk) disable iff (!i_resetn)
      (i_core_op.mul && !wr_en) |=> ({aux_q, acc_q} == $past(product));
   endproperty
   a_mul: assert property (p_mul) else $error("product misplaced");

   property p_div;
      @(posedge i_clk) disable iff (!i_resetn)
      (i_core_op.div && !i_core_op.mul && !wr_en && (acc_q != 8'h00))
         |=> ((acc_q == $past(aux_q) / $past(acc_q)) && (aux_q == $past(aux_q) % $past(acc_q)));
   endproperty
   a_div: assert property (p_div) else $error("divide result wrong");

   property p_sel_read;
      @(posedge i_clk) disable iff (!i_resetn)
      (i_byte_req.rd && (i_byte_req.addr == CSR_A_PTR_SEL))
         |=> ((o_rdata[7:1] == 7'h00) && (o_rdata[0] == $past(choice_q)));
   endproperty
   a_sel_read: assert property (p_sel_read) else $error("choice read wrong");

   property p_sleep_wake;
      @(posedge i_clk) disable iff (!i_resetn)
      (sleep_q && i_ext_wake && !wr_en) |=> ##1 !o_power_down;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not cleared");

   property p_idle_wake;
      @(posedge i_clk) disable iff (!i_resetn)
      (idle_q && i_per_wake && !wr_en) |=> ##1 !o_cpu_clk_stop;
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle not cleared");

   property p_boot_flag;
      @(posedge i_clk) disable iff (!i_resetn)
      // One spare cycle so a release of reset with the pin high cannot fire it
      i_mode_select_pin [*3] |=> boot_q;
   endproperty
   a_boot_flag: assert property (p_boot_flag) else $error("boot flag not set");

endmodule

// ==== shared/csr_pkg.sv ====
// Package of constants and bundles for the CPU special register space
package csr_pkg;
   // Core register byte addresses
   localparam logic [7:0] CSR_A_STACK = 8'h81;
   localparam logic [7:0] CSR_A_PTR_LO = 8'h82;
   localparam logic [7:0] CSR_A_PTR_HI = 8'h83;
   localparam logic [7:0] CSR_A_POWER = 8'h87;
   localparam logic [7:0] CSR_A_PTR_SEL = 8'hA2;
   localparam logic [7:0] CSR_A_WCTRL = 8'hC0;
   localparam logic [7:0] CSR_A_STATUS = 8'hD0;
   localparam logic [7:0] CSR_A_ACC = 8'hE0;
   localparam logic [7:0] CSR_A_AUX = 8'hF0;
   // Page port location, and peripheral locations with a nonzero reset value
   localparam logic [7:0] CSR_A_PAGE = 8'hA0;
   localparam logic [7:0] CSR_A_GATE0 = 8'h98;
   localparam logic [7:0] CSR_A_GATE2 = 8'h9A;
   localparam logic [7:0] CSR_A_GATE3 = 8'h92;
   // Reset values
   localparam logic [7:0] CSR_RST_STACK = 8'h07;
   localparam logic [7:0] CSR_RST_ZERO = 8'h00;
   localparam logic [7:0] CSR_RST_GATE0 = 8'h70;
   localparam logic [7:0] CSR_RST_GATE2 = 8'h07;
   localparam logic [7:0] CSR_RST_GATE3 = 8'h01;
   // Field positions
   localparam int CSR_WC_BOOT = 6;
   localparam int CSR_WC_LOWPWR = 2;
   localparam int CSR_WC_FIXED1 = 1;
   localparam int CSR_ST_CY = 7;
   localparam int CSR_ST_AC = 6;
   localparam int CSR_ST_F0 = 5;
   localparam int CSR_ST_BANK_HI = 4;
   localparam int CSR_ST_BANK_LO = 3;
   localparam int CSR_ST_OV = 2;
   localparam int CSR_ST_F1 = 1;
   localparam int CSR_ST_PAR = 0;
   localparam int CSR_PC_SLEEP = 1;
   localparam int CSR_PC_IDLE = 0;
   localparam int CSR_PS_CHOICE = 0;
   // Bit address split: byte part above, bit index below
   localparam int CSR_BIT_IDX_W = 3;
   localparam int CSR_PER_DEPTH = 128;

   // Byte access from the instruction stream
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } csr_byte_req_t;

   // Single-bit access from the instruction stream
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic wdata;
   } csr_bit_req_t;

   // Core datapath operations acting on core registers
   typedef struct packed {
      logic acc_wr;
      logic [7:0] acc_data;
      logic flag_wr;
      logic cy;
      logic ac;
      logic ov;
      logic mul;
      logic div;
      logic push;
      logic pop;
      logic ptr_inc;
      logic ptr_load;
      logic [15:0] ptr_data;
   } csr_core_op_t;

   // Write notice to peripherals owning a placed location
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } csr_per_wr_t;
endpackage

// ==== tb/testbench.sv ====
// Self-checking testbench for the CPU special register space
`timescale 1ns/1ps
module testbench;
   import csr_pkg::*;
   // Compares one value and counts it
   `define CHK(nm, ex, got) \
      begin \
         checks_done++; \
         if ((got) !== (ex)) \
         begin \
            n_mismatch++; \
            $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
         end \
      end
   // Stimulus
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   csr_byte_req_t byte_req = '0;
   csr_bit_req_t bit_req = '0;
   csr_core_op_t core_op = '0;
   logic ext_wake = 1'b0;
   logic per_wake = 1'b0;
   logic mode_pin = 1'b0;
   // Observed outputs
   logic [7:0] rdata, acc, sp, page;
   logic bit_rdata, rvalid, lowpwr, pdown, clkstop;
   logic [15:0] dptr;
   logic [1:0] bank;
   csr_per_wr_t per_wr;
   // Counters and expected read notes (bit 8 marks a bit read)
   int n_mismatch = 0;
   int checks_done = 0;
   logic [8:0] notes[$];

   // Clock of 100 ns period
   always #50 i_clk = ~i_clk;

   csr_space csr_space_i (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_byte_req(byte_req), .i_bit_req(bit_req),
      .o_rdata(rdata), .o_bit_rdata(bit_rdata), .o_rvalid(rvalid), .i_core_op(core_op),
      .i_ext_wake(ext_wake), .i_per_wake(per_wake), .i_mode_select_pin(mode_pin),
      .o_acc(acc), .o_stack_ptr(sp), .o_data_ptr(dptr), .o_bank_select_field(bank),
      .o_page_address_port(page), .o_nvm_low_power_enable(lowpwr),
      .o_power_down(pdown), .o_cpu_clk_stop(clkstop), .o_per_wr(per_wr));

   // Prints the counts and the verdict, then stops
   task automatic end_sim;
      $display("Comparisons %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Byte write, held for one taking edge
   task automatic bwr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      byte_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge i_clk);
      byte_req <= '0;
   endtask
   // Byte read, expected value noted for the monitor
   task automatic brd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_clk);
      notes.push_back({1'b0, e});
      byte_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge i_clk);
      byte_req <= '0;
   endtask
   // Single-bit write at a bit address
   task automatic bitwr(input logic [7:0] a, input logic b);
      @(posedge i_clk);
      bit_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: b};
      @(posedge i_clk);
      bit_req <= '0;
   endtask
   // Single-bit read at a bit address
   task automatic bitrd(input logic [7:0] a, input logic e);
      @(posedge i_clk);
      notes.push_back({1'b1, 7'h00, e});
      bit_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 1'b0};
      @(posedge i_clk);
      bit_req <= '0;
   endtask
   // One-cycle core datapath strobe
   task automatic op(input csr_core_op_t o);
      @(posedge i_clk);
      core_op <= o;
      @(posedge i_clk);
      core_op <= '0;
   endtask
   // Lets registered copies of state catch up
   task automatic settle;
      repeat (2) @(posedge i_clk);
      #1;
   endtask

   // Monitor: each read answer takes the oldest note
   always @(posedge i_clk)
   begin
      logic [8:0] n;
      if (rvalid === 1'b1)
      begin
         // An answer with no request behind it is an error
         if (notes.size() == 0)
         begin
            n_mismatch++;
            $display("MISMATCH read answer expected none seen %h", rdata);
         end
         else
         begin
            n = notes.pop_front();
            if (n[8])
               `CHK("bit read", n[0], bit_rdata)
            else
               `CHK("byte read", n[7:0], rdata)
         end
      end
   end

   // Watchdog well beyond the expected run length
   initial
   begin
      repeat (20000) @(posedge i_clk);
      n_mismatch++;
      end_sim();
   end

   // Main sequence
   initial
   begin
      logic [7:0] a, b, v;
      logic [15:0] p;
      csr_core_op_t o;
      logic [15:0] rv[$] = '{{CSR_A_STACK, CSR_RST_STACK}, {CSR_A_PTR_LO, 8'h00},
         {CSR_A_PTR_HI, 8'h00}, {CSR_A_POWER, 8'h00}, {CSR_A_PTR_SEL, 8'h00},
         {CSR_A_STATUS, 8'h00}, {CSR_A_ACC, 8'h00}, {CSR_A_AUX, 8'h00}, {CSR_A_WCTRL, 8'h02},
         {CSR_A_GATE0, 8'h70}, {CSR_A_GATE2, 8'h07}, {CSR_A_GATE3, 8'h01}};
      logic [7:0] placed[$] = '{8'h80, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h98,
         8'h99, 8'h9A, 8'h92, 8'hA8, 8'hB8, 8'hE8, 8'hE9, 8'hF8, 8'hF9, 8'h91, 8'hD8,
         8'hA9, 8'hD2};
      logic [7:0] empty[$] = '{8'h84, 8'h86, 8'h8E, 8'h93, 8'h9B, 8'hA1, 8'hC8, 8'hCF, 8'hD1};
      void'($urandom(32'hEAEC));
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'b1;
      // Reset values of the core registers and clock gates
      foreach (rv[i])
         brd(rv[i][15:8], rv[i][7:0]);
      // Empty locations ignore writes and read zero
      foreach (empty[i])
      begin
         bwr(empty[i], 8'($urandom));
         brd(empty[i], 8'h00);
      end
      // Placed peripheral locations store and give a write notice
      foreach (placed[i])
      begin
         v = 8'($urandom);
         bwr(placed[i], v);
         #1;
         `CHK("notice", {1'b1, placed[i], v}, per_wr)
         brd(placed[i], v);
      end
      v = 8'($urandom);
      bwr(CSR_A_PAGE, v);
      settle();
      `CHK("page port", v, page)
      // Parity follows the accumulator
      repeat (4)
      begin
         v = 8'($urandom);
         bwr(CSR_A_ACC, v);
         settle();
         `CHK("acc", v, acc)
         brd(CSR_A_STATUS, {7'h00, ^v});
      end
      // Every bank value reaches the bank output
      for (int k = 0; k < 4; k++)
      begin
         bwr(CSR_A_STATUS, {3'b000, 2'(k), 3'b000});
         settle();
         `CHK("bank", 2'(k), bank)
      end
      bwr(CSR_A_STATUS, 8'hFA);
      brd(CSR_A_STATUS, {7'h7D, ^v});
      // Bit access on bit-addressable places
      bwr(CSR_A_STATUS, 8'h00);
      bitwr(CSR_A_STATUS | 8'h07, 1'b1);
      brd(CSR_A_STATUS, {7'h40, ^v});
      bitrd(CSR_A_STATUS | 8'h07, 1'b1);
      bitwr(CSR_A_ACC | 8'h05, ~v[5]);
      v[5] = ~v[5];
      brd(CSR_A_ACC, v);
      bitwr(8'hCB, 1'b1);
      brd(8'hC8, 8'h00);
      // Multiply and divide
      repeat (3)
      begin
         a = 8'($urandom);
         b = 8'($urandom);
         p = 16'(a) * 16'(b);
         bwr(CSR_A_STATUS, 8'h00);
         bwr(CSR_A_ACC, a);
         bwr(CSR_A_AUX, b);
         o = '0;
         o.mul = 1'b1;
         op(o);
         brd(CSR_A_AUX, p[15:8]);
         brd(CSR_A_ACC, p[7:0]);
         brd(CSR_A_STATUS, {5'h00, p[15:8] != 8'h00, 1'b0, ^p[7:0]});
         b = 8'($urandom_range(1, 255));
         bwr(CSR_A_STATUS, 8'h00);
         bwr(CSR_A_AUX, a);
         bwr(CSR_A_ACC, b);
         o = '0;
         o.div = 1'b1;
         op(o);
         brd(CSR_A_ACC, a / b);
         brd(CSR_A_AUX, a % b);
      end
      bwr(CSR_A_ACC, 8'h00);
      bwr(CSR_A_AUX, 8'h5C);
      op(o);
      brd(CSR_A_AUX, 8'h5C);
      brd(CSR_A_STATUS, 8'h04);
      // Single-bit set on the auxiliary register
      bitwr(CSR_A_AUX | 8'h01, 1'b1);
      brd(CSR_A_AUX, 8'h5E);
      // Core accumulator load and arithmetic flag update
      o = '0;
      o.acc_wr = 1'b1;
      o.acc_data = 8'($urandom);
      o.flag_wr = 1'b1;
      o.cy = 1'b1;
      o.ac = 1'b1;
      o.ov = 1'($urandom);
      op(o);
      brd(CSR_A_ACC, o.acc_data);
      brd(CSR_A_STATUS, {2'b11, 3'b000, o.ov, 1'b0, ^o.acc_data});
      // Stack pointer around pushes and pops
      o = '0;
      o.push = 1'b1;
      op(o);
      op(o);
      settle();
      `CHK("stack push", 8'h09, sp)
      o = '0;
      o.pop = 1'b1;
      op(o);
      settle();
      `CHK("stack pop", 8'h08, sp)
      // Two data pointers
      a = 8'($urandom);
      b = 8'($urandom);
      bwr(CSR_A_PTR_LO, a);
      bwr(CSR_A_PTR_HI, b);
      settle();
      `CHK("pointer", {b, a}, dptr)
      bwr(CSR_A_PTR_SEL, 8'hFF);
      brd(CSR_A_PTR_SEL, 8'h01);
      settle();
      `CHK("second pointer", 16'h0000, dptr)
      p = 16'($urandom);
      o = '0;
      o.ptr_load = 1'b1;
      o.ptr_data = p;
      op(o);
      o = '0;
      o.ptr_inc = 1'b1;
      op(o);
      p = p + 16'h0001;
      brd(CSR_A_PTR_LO, p[7:0]);
      brd(CSR_A_PTR_HI, p[15:8]);
      bwr(CSR_A_PTR_SEL, 8'h00);
      settle();
      `CHK("first pointer", {b, a}, dptr)
      // Power-down and idle, woken, with contents kept
      v = 8'($urandom);
      bwr(CSR_A_ACC, v);
      bwr(CSR_A_POWER, 8'hFE);
      settle();
      `CHK("power down", 1'b1, pdown)
      brd(CSR_A_POWER, 8'h02);
      @(posedge i_clk);
      ext_wake <= 1'b1;
      @(posedge i_clk);
      ext_wake <= 1'b0;
      settle();
      `CHK("power down wake", 1'b0, pdown)
      bwr(CSR_A_POWER, 8'h01);
      settle();
      `CHK("clock stop", 1'b1, clkstop)
      @(posedge i_clk);
      per_wake <= 1'b1;
      @(posedge i_clk);
      per_wake <= 1'b0;
      settle();
      `CHK("clock stop wake", 1'b0, clkstop)
      brd(CSR_A_ACC, v);
      // Write control: boot flag and low-power fetch
      bwr(CSR_A_WCTRL, 8'hFF);
      brd(CSR_A_WCTRL, 8'h06);
      settle();
      `CHK("low power", 1'b1, lowpwr)
      @(posedge i_clk);
      mode_pin <= 1'b1;
      repeat (3) @(posedge i_clk);
      brd(CSR_A_WCTRL, 8'h46);
      bitrd(CSR_A_WCTRL | 8'h06, 1'b1);
      bwr(CSR_A_WCTRL, 8'h00);
      settle();
      `CHK("low power off", 1'b0, lowpwr)
      // Second reset in mid-run
      bwr(CSR_A_STACK, 8'h33);
      @(posedge i_clk);
      i_resetn <= 1'b0;
      #1;
      `CHK("stack in reset", CSR_RST_STACK, sp)
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'b1;
      brd(CSR_A_STACK, CSR_RST_STACK);
      brd(CSR_A_GATE0, CSR_RST_GATE0);
      repeat (3) @(posedge i_clk);
      `CHK("pending reads", 0, notes.size())
      end_sim();
   end
endmodule
